// >>> rtl/refdsel_pkg.sv
package refdsel_pkg;
    // ************************************************************
    // register map (word index, byte address is four times it)
    // ************************************************************
    localparam logic [3:0]  REG_PATH_IDX   = 4'h1;   // reference path control
    localparam logic [3:0]  REG_DIV_IDX    = 4'h3;   // reference divider control
    localparam logic [3:0]  REG_GPIO_IDX   = 4'h4;   // pin function / output level
    localparam logic [3:0]  REG_STAT_IDX   = 4'h5;   // block status, read only
    localparam logic [31:0] UNMAPPED_VAL   = 32'hdead_beef;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DIV_RATIO_W     = 14;
    localparam int DIV_MAN_SEL_BIT = 14;
    localparam int DIV_AUTO_BIT    = 15;
    localparam int PATH_SIN_EN     = 0;
    localparam int PATH_SQ_EN      = 1;
    localparam int PATH_DIV_EN     = 2;
    localparam int PATH_SIN_SEL    = 3;
    localparam int PATH_SQ_DIG     = 4;
    localparam int PATH_SIN_DIG    = 5;
    localparam int PATH_DSM_SIN    = 6;
    localparam int GPIO_TRIG_BIT   = 5;
    localparam int GPIO_LD_SEL_BIT = 0;
    localparam int GPIO_OUT_BIT    = 1;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] DIV_RESET   = 16'h8001;  // auto mode, ratio 1
    localparam logic [6:0]  PATH_RESET  = 7'h12;     // square buffer, square to digital
    localparam logic [5:0]  GPIO_RESET  = 6'h01;     // lock detect on shared pin

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ        = 10;
    localparam int REF_MAX_MHZ    = 250;
    localparam int RD_LAT_CYCLES  = 1;
endpackage : refdsel_pkg

// >>> rtl/refdsel_divider.sv
`timescale 1ns/1ps
// ************************************************************
// programmable integer divider, one output cycle per n inputs
// ************************************************************
module refdsel_divider #(
    parameter int WIDTH = 14
) (
    input  wire logic             clk_i,
    input  wire logic             sys_rst_i,
    input  wire logic             ref_tick_i,
    input  wire logic             run_i,
    input  wire logic [WIDTH-1:0] ratio_i,
    output logic                  div_pulse_o
);
    import refdsel_pkg::*;

    logic [WIDTH-1:0] cnt_q, cnt_d;
    logic             pulse_q, pulse_d;

    // count reference ticks, wrap after ratio-1 (ratio 0 treated as 1)
    always_comb begin
        cnt_d   = cnt_q;
        pulse_d = 1'b0;
        if (!run_i) begin
            cnt_d = '0;
        end else if (ref_tick_i) begin
            if (cnt_q + WIDTH'(1) >= ratio_i) begin
                cnt_d   = '0;
                pulse_d = 1'b1;
            end else begin
                cnt_d = cnt_q + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign div_pulse_o = pulse_q;

    // at ratio two, a pulse is never followed by another pulse in the next cycle
    period_min_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        pulse_q && ratio_i == WIDTH'(2) && $stable(ratio_i) && run_i |=> !pulse_q)
        else $error("divider pulsed twice in a row at ratio two");
endmodule : refdsel_divider

// >>> rtl/refdsel_top.sv
`timescale 1ns/1ps
// Summary of operation
// - after reset the square-wave reference buffer is the selected source
// - 14-bit ratio n (1 to 16383) in control register bits 13:0; divided output is the reference divided by 2n
// - divider works for reference inputs up to clk/4 (2.5 MHz at the 10 MHz clock), each level held two clocks
// - auto bit 15 set makes manual select bit and divider enable ignored
// - auto mode, ratio two or more runs divider and feeds divided output
// - auto mode, ratio one stops divider and feeds undivided reference
// - manual mode, divider runs only while path enable bit 2 is one
// - manual bit 14 picks divided or undivided; divider may run unused
// - modulator clock from square input when square-digital on, modulator-sine bit 6 off
// - third pin is tristate bidirectional, trigger input when selected
// - one pin carries lock detect or serial read data
module refdsel_top (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    // reference inputs, sampled as levels
    input  wire logic        square_ref_pin_i,
    input  wire logic        sine_reference_pin_i,
    // outputs to phase detector and modulator
    output logic             pfd_ref_o,
    output logic             dsm_clk_o,
    output logic             div_running_o,
    // shared pins
    input  wire logic        gp_pin_three_i,
    output logic             gp_pin_three_o,
    output logic             gp_pin_three_oe_o,
    output logic             ramp_trigger_o,
    input  wire logic        lock_detect_i,
    input  wire logic        serial_read_data_i,
    output logic             lock_or_read_out_pin_o
);
    import refdsel_pkg::*;

    // ************************************************************
    // pin synchronisers, three stages
    // ************************************************************
    logic [2:0] sq_sync_q, sin_sync_q, gp_sync_q;
    logic       sq_lvl_q, sin_lvl_q, gp_lvl_q;
    logic       sq_lvl_d, sin_lvl_d, gp_lvl_d;

    // a change counts once stages two and three agree
    always_comb begin
        sq_lvl_d  = (sq_sync_q[1] == sq_sync_q[2]) ? sq_sync_q[2] : sq_lvl_q;
        sin_lvl_d = (sin_sync_q[1] == sin_sync_q[2]) ? sin_sync_q[2] : sin_lvl_q;
        gp_lvl_d  = (gp_sync_q[1] == gp_sync_q[2]) ? gp_sync_q[2] : gp_lvl_q;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sq_sync_q  <= 3'h0;
            sin_sync_q <= 3'h0;
            gp_sync_q  <= 3'h0;
            sq_lvl_q   <= 1'b0;
            sin_lvl_q  <= 1'b0;
            gp_lvl_q   <= 1'b0;
        end else begin
            sq_sync_q  <= {sq_sync_q[1:0], square_ref_pin_i};
            sin_sync_q <= {sin_sync_q[1:0], sine_reference_pin_i};
            gp_sync_q  <= {gp_sync_q[1:0], gp_pin_three_i};
            sq_lvl_q   <= sq_lvl_d;
            sin_lvl_q  <= sin_lvl_d;
            gp_lvl_q   <= gp_lvl_d;
        end
    end

    // ************************************************************
    // register file
    // ************************************************************
    logic [15:0] div_ctrl_q, div_ctrl_d;
    logic [6:0]  path_ctrl_q, path_ctrl_d;
    logic [5:0]  gpio_ctrl_q, gpio_ctrl_d;
    logic [31:0] rdata_q, rdata_d;
    logic        rd_done_q, rd_done_d;
    logic        wr_en;

    // writes finish in the cycle they arrive; reads wait one cycle
    assign wr_en = avs_write_i && !avs_read_i;
    assign avs_waitrequest_o = avs_read_i && !rd_done_q;

    always_comb begin
        div_ctrl_d  = div_ctrl_q;
        path_ctrl_d = path_ctrl_q;
        gpio_ctrl_d = gpio_ctrl_q;
        rd_done_d   = avs_read_i && !rd_done_q;
        rdata_d     = rdata_q;
        if (wr_en) begin
            case (avs_address_i)
                REG_DIV_IDX: begin
                    if (avs_byteenable_i[0]) div_ctrl_d[7:0]  = avs_writedata_i[7:0];
                    if (avs_byteenable_i[1]) div_ctrl_d[15:8] = avs_writedata_i[15:8];
                end
                REG_PATH_IDX: begin
                    if (avs_byteenable_i[0]) path_ctrl_d = avs_writedata_i[6:0];
                end
                REG_GPIO_IDX: begin
                    if (avs_byteenable_i[0]) gpio_ctrl_d = avs_writedata_i[5:0];
                end
                default: begin
                end
            endcase
        end
        if (avs_read_i && !rd_done_q) begin
            case (avs_address_i)
                REG_DIV_IDX:  rdata_d = {16'h0000, div_ctrl_q};
                REG_PATH_IDX: rdata_d = {25'h0000000, path_ctrl_q};
                REG_GPIO_IDX: rdata_d = {26'h0000000, gpio_ctrl_q};
                REG_STAT_IDX: rdata_d = {28'h0000000, gp_lvl_q, dsm_clk_o,
                                         div_running_o, pfd_ref_o};
                default:      rdata_d = UNMAPPED_VAL;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_ctrl_q  <= DIV_RESET;
            path_ctrl_q <= PATH_RESET;
            gpio_ctrl_q <= GPIO_RESET;
            rdata_q     <= 32'h0000_0000;
            rd_done_q   <= 1'b0;
        end else begin
            div_ctrl_q  <= div_ctrl_d;
            path_ctrl_q <= path_ctrl_d;
            gpio_ctrl_q <= gpio_ctrl_d;
            rdata_q     <= rdata_d;
            rd_done_q   <= rd_done_d;
        end
    end

    assign avs_readdata_o = rdata_q;

    // ************************************************************
    // reference selection and divider control
    // ************************************************************
    logic [DIV_RATIO_W-1:0] ratio;
    logic auto_mode, div_run, use_div, sel_ref, sel_ref_q, ref_tick, div_pulse;
    logic pfd_q, pfd_d, dsm_q, dsm_d;

    assign ratio     = div_ctrl_q[DIV_RATIO_W-1:0];
    assign auto_mode = div_ctrl_q[DIV_AUTO_BIT];

    // auto mode ignores the manual bits entirely
    always_comb begin
        if (auto_mode) begin
            div_run = (ratio >= DIV_RATIO_W'(2));
            use_div = div_run;
        end else begin
            div_run = path_ctrl_q[PATH_DIV_EN];
            use_div = div_ctrl_q[DIV_MAN_SEL_BIT];
        end
        // sine only when its buffer and mux are on, else square if its buffer is on, else low
        if (path_ctrl_q[PATH_SIN_SEL] && path_ctrl_q[PATH_SIN_EN]) begin
            sel_ref = sin_lvl_q;
        end else begin
            sel_ref = path_ctrl_q[PATH_SQ_EN] ? sq_lvl_q : 1'b0;
        end
    end

    // rising edge of the selected reference; the synchroniser filter limits usable rate to clk/4
    assign ref_tick = sel_ref && !sel_ref_q;

    refdsel_divider #(
        .WIDTH (DIV_RATIO_W)
    ) u_refdsel_divider (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .ref_tick_i  (ref_tick),
        .run_i       (div_run),
        .ratio_i     (ratio),
        .div_pulse_o (div_pulse)
    );

    // divided path toggles per pulse, undivided follows the reference
    always_comb begin
        pfd_d = use_div ? (div_run ? (pfd_q ^ div_pulse) : 1'b0) : sel_ref;
        if (path_ctrl_q[PATH_SQ_DIG] && !path_ctrl_q[PATH_DSM_SIN]) begin
            dsm_d = sq_lvl_q;
        end else if (path_ctrl_q[PATH_SIN_DIG] && path_ctrl_q[PATH_DSM_SIN]) begin
            dsm_d = sin_lvl_q;
        end else begin
            dsm_d = 1'b0;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sel_ref_q <= 1'b0;
            pfd_q     <= 1'b0;
            dsm_q     <= 1'b0;
        end else begin
            sel_ref_q <= sel_ref;
            pfd_q     <= pfd_d;
            dsm_q     <= dsm_d;
        end
    end

    assign pfd_ref_o     = pfd_q;
    assign dsm_clk_o     = dsm_q;
    assign div_running_o = div_run;

    // ************************************************************
    // shared pins
    // ************************************************************
    // trigger mode releases the pin and listens to it
    assign gp_pin_three_oe_o = !gpio_ctrl_q[GPIO_TRIG_BIT];
    assign gp_pin_three_o    = gpio_ctrl_q[GPIO_OUT_BIT];
    assign ramp_trigger_o    = gpio_ctrl_q[GPIO_TRIG_BIT] && gp_lvl_q;
    assign lock_or_read_out_pin_o = gpio_ctrl_q[GPIO_LD_SEL_BIT] ?
                                    lock_detect_i : serial_read_data_i;

    // ************************************************************
    // checks
    // ************************************************************
    // named steps shared by the properties below
    sequence ratio_one_s;
        auto_mode && ratio == DIV_RATIO_W'(1);
    endsequence

    sequence ratio_multi_s;
        auto_mode && ratio >= DIV_RATIO_W'(2);
    endsequence

    sequence manual_bypass_s;
        !auto_mode && !div_ctrl_q[DIV_MAN_SEL_BIT];
    endsequence

    sequence divided_pulse_s;
        use_div && div_run && div_pulse;
    endsequence

    sequence divided_hold_s;
        use_div && div_run && !div_pulse;
    endsequence

    sequence square_to_dsm_s;
        path_ctrl_q[PATH_SQ_DIG] && !path_ctrl_q[PATH_DSM_SIN];
    endsequence

    sequence read_first_s;
        avs_read_i && !rd_done_q;
    endsequence

    // ratio decode in automatic mode; the manual bits must not leak in
    auto_bypass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ratio_one_s |-> !div_running_o)
        else $error("divider running at ratio one in auto mode");
    auto_divide_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ratio_multi_s |-> div_running_o)
        else $error("divider stopped at ratio two or more");
    auto_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ratio_one_s |=> pfd_ref_o == $past(sel_ref))
        else $error("auto bypass not passing the reference");

    // manual mode: enable bit runs the divider, select bit picks the path
    manual_run_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !auto_mode |-> div_running_o == path_ctrl_q[PATH_DIV_EN])
        else $error("manual divider run not following enable");
    undiv_path_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        manual_bypass_s |=> pfd_ref_o == $past(sel_ref))
        else $error("undivided path not passed through");
    div_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        use_div && !div_run |=> !pfd_ref_o)
        else $error("stopped divider still driving the detector");

    // divided output toggles once per pulse and holds in between
    div_toggle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        divided_pulse_s |=> pfd_ref_o != $past(pfd_ref_o))
        else $error("divided output missed a toggle");
    div_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        divided_hold_s |=> pfd_ref_o == $past(pfd_ref_o))
        else $error("divided output toggled without a pulse");

    // modulator clock source; quiet when no digital path is enabled
    dsm_square_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        square_to_dsm_s |=> dsm_clk_o == $past(sq_lvl_q))
        else $error("modulator clock not from square input");
    dsm_quiet_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !path_ctrl_q[PATH_SQ_DIG] && !path_ctrl_q[PATH_SIN_DIG] |=> !dsm_clk_o)
        else $error("modulator clock running with no source enabled");

    // shared pins
    trig_tristate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        gpio_ctrl_q[GPIO_TRIG_BIT] |-> !gp_pin_three_oe_o)
        else $error("third pin driven in trigger mode");
    pin_drive_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !gpio_ctrl_q[GPIO_TRIG_BIT] |-> gp_pin_three_oe_o)
        else $error("third pin released outside trigger mode");
    trig_idle_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !gpio_ctrl_q[GPIO_TRIG_BIT] |-> !ramp_trigger_o)
        else $error("ramp trigger seen outside trigger mode");
    shared_pin_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !gpio_ctrl_q[GPIO_LD_SEL_BIT] |-> lock_or_read_out_pin_o == serial_read_data_i)
        else $error("shared pin not carrying read data");
    lock_pin_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        gpio_ctrl_q[GPIO_LD_SEL_BIT] |-> lock_or_read_out_pin_o == lock_detect_i)
        else $error("shared pin not carrying lock detect");

    // bus handshake: reads wait one cycle, writes never wait
    read_wait_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        read_first_s |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
        else $error("read answer not one cycle late");
    write_nowait_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        avs_write_i && !avs_read_i |-> !avs_waitrequest_o)
        else $error("write held off by waitrequest");
endmodule : refdsel_top

// >>> dv/refdsel_ref_osc.sv
`timescale 1ns/1ps
// ************************************************************
// reference oscillators feeding the square and sine inputs
// ************************************************************
module refdsel_ref_osc #(
    parameter int HALF_SQ  = 4,
    parameter int HALF_SIN = 6
) (
    input  wire logic clk_i,
    input  wire logic sin_run_i,
    output logic      square_o,
    output logic      sine_o
);
    int sq_cnt = 0;
    int sin_cnt = 0;
    initial square_o = 1'b0;
    initial sine_o = 1'b0;
    // periods are whole clock multiples so detector periods are exact
    always @(posedge clk_i) begin
        sq_cnt <= (sq_cnt == HALF_SQ - 1) ? 0 : sq_cnt + 1;
        if (sq_cnt == HALF_SQ - 1) square_o <= ~square_o;
        sin_cnt <= (sin_cnt == HALF_SIN - 1) ? 0 : sin_cnt + 1;
        if (sin_run_i && sin_cnt == HALF_SIN - 1) sine_o <= ~sine_o;
    end
endmodule : refdsel_ref_osc

// >>> dv/reference_divider_select_test.sv
`timescale 1ns/1ps
module reference_divider_select_test;
    import refdsel_pkg::*;
    localparam int P_SQ  = 8;
    localparam int P_SIN = 12;
    logic        clk_i            = 1'b0;
    logic        sys_rst_i        = 1'b1;
    logic [3:0]  avs_address_i    = 4'h0;
    logic        avs_read_i       = 1'b0;
    logic        avs_write_i      = 1'b0;
    logic [31:0] avs_writedata_i  = 32'h0;
    logic [31:0] avs_readdata_o;
    logic        avs_waitrequest_o;
    logic        sq_pin, sin_pin, pfd_ref_o, dsm_clk_o, div_running_o;
    logic        gp_o, gp_oe, gp_wire, ramp_trigger_o, lock_pin;
    logic        tb_gp            = 1'b0;
    logic        sin_run          = 1'b0;
    logic        lock_detect_i    = 1'b0;
    logic        serial_read_data_i = 1'b0;
    logic [31:0] q;
    int          num_errors       = 0;
    int          checks_done      = 0;
    // third pin wire: design drives when enabled, bench otherwise
    assign gp_wire = gp_oe ? gp_o : tb_gp;
    always #50 clk_i = ~clk_i;
    refdsel_top u_refdsel_top (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hf),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .square_ref_pin_i(sq_pin), .sine_reference_pin_i(sin_pin),
        .pfd_ref_o(pfd_ref_o), .dsm_clk_o(dsm_clk_o), .div_running_o(div_running_o),
        .gp_pin_three_i(gp_wire), .gp_pin_three_o(gp_o), .gp_pin_three_oe_o(gp_oe),
        .ramp_trigger_o(ramp_trigger_o), .lock_detect_i(lock_detect_i),
        .serial_read_data_i(serial_read_data_i), .lock_or_read_out_pin_o(lock_pin));
    refdsel_ref_osc #(.HALF_SQ(P_SQ / 2), .HALF_SIN(P_SIN / 2)) u_refdsel_ref_osc (
        .clk_i(clk_i), .sin_run_i(sin_run), .square_o(sq_pin), .sine_o(sin_pin));
    // ************************************************************
    // bench tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // request held until waitrequest is sampled low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 100);
        if (n >= 100) num_errors++;
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        // one more edge so register-driven outputs show the write
        @(posedge clk_i);
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd
    // cycles between the third and fourth rising edges, skipping settling
    task automatic period(input bit dsm, input int exp);
        int n, c, prev, last;
        logic v, p;
        n = 0; c = 0; prev = 0; last = 0; p = 1'b1;
        while (c < 4 && n < 3000) begin
            @(posedge clk_i);
            n++;
            v = dsm ? dsm_clk_o : pfd_ref_o;
            if (v === 1'b1 && p === 1'b0) begin
                last = n - prev;
                prev = n;
                c++;
            end
            p = v;
        end
        chk(32'(last), 32'(exp));
    endtask : period
    task automatic summarize();
        $display("checks=%0d errors=%0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        int r;
        repeat (20) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(REG_DIV_IDX, 32'h0000_8001);
        rd(REG_PATH_IDX, 32'h0000_0012);
        rd(REG_GPIO_IDX, 32'h0000_0001);
        rd(4'h7, UNMAPPED_VAL);
        chk(32'(div_running_o), 32'h0);
        period(1'b0, P_SQ);
        period(1'b1, P_SQ);
        // ratios kept low so the detector rate stays in range
        for (int i = 0; i < 3; i++) begin
            r = (i == 0) ? 2 : (i == 1) ? 3 : 5;
            bus(1'b1, REG_DIV_IDX, 32'h8000 | 32'(r));
            chk(32'(div_running_o), 32'h1);
            period(1'b0, 2 * r * P_SQ);
        end
        bus(1'b1, REG_DIV_IDX, 32'hffff_ffff);
        rd(REG_DIV_IDX, 32'h0000_ffff);
        bus(1'b1, REG_PATH_IDX, 32'h16);
        bus(1'b1, REG_DIV_IDX, 32'hc001);
        chk(32'(div_running_o), 32'h0);
        period(1'b0, P_SQ);
        bus(1'b1, REG_DIV_IDX, 32'h4003);
        chk(32'(div_running_o), 32'h1);
        period(1'b0, 6 * P_SQ);
        bus(1'b1, REG_DIV_IDX, 32'h0003);
        chk(32'(div_running_o), 32'h1);
        period(1'b0, P_SQ);
        bus(1'b1, REG_PATH_IDX, 32'h12);
        chk(32'(div_running_o), 32'h0);
        bus(1'b1, REG_DIV_IDX, 32'h4003);
        @(posedge clk_i);
        chk(32'(pfd_ref_o), 32'h0);
        bus(1'b1, REG_DIV_IDX, 32'h8001);
        sin_run <= 1'b1;
        bus(1'b1, REG_PATH_IDX, 32'h1b);
        period(1'b0, P_SIN);
        period(1'b1, P_SQ);
        bus(1'b1, REG_PATH_IDX, 32'h09);
        period(1'b0, P_SIN);
        bus(1'b1, REG_GPIO_IDX, 32'h20);
        chk(32'(gp_oe), 32'h0);
        tb_gp <= 1'b1;
        repeat (5) @(posedge clk_i);
        chk(32'(ramp_trigger_o), 32'h1);
        bus(1'b1, REG_GPIO_IDX, 32'h02);
        chk(32'({gp_oe, gp_o}), 32'h3);
        lock_detect_i <= 1'b1;
        bus(1'b1, REG_GPIO_IDX, 32'h01);
        chk(32'(lock_pin), 32'h1);
        lock_detect_i      <= 1'b0;
        serial_read_data_i <= 1'b1;
        bus(1'b1, REG_GPIO_IDX, 32'h00);
        chk(32'(lock_pin), 32'h1);
        // mid-run reset must bring back the square default
        sys_rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(REG_PATH_IDX, 32'h0000_0012);
        rd(REG_GPIO_IDX, 32'h0000_0001);
        period(1'b0, P_SQ);
        summarize();
    end
    // hang guard, well beyond the expected run length
    initial begin
        #3_000_000;
        num_errors++;
        summarize();
    end
endmodule : reference_divider_select_test
